// ==== rtl/temp_monitor_status_id_regs.sv ====
// Temperature monitor register bank: serial slave, id, filter, hysteresis and limit status
// Operation
// - Reading pointer FEh returns the fixed maker identity code.
// - Reading pointer FDh returns the part identity code of the variant.
// - Both identity registers are read-only; writes change nothing.
// - Consecutive-count register is read/write at 22h, resets to 70h.
// - Bits 6:4 overtemp count, bits 3:1 alert count, bits 7,0 zero.
// - Hysteresis register is 8-bit read/write at 21h, resets to 0Ah.
// - Open flags bit 2 and bit 1 per remote; read clears once fault gone.
// - Mask per channel; masked channels drive the alert output on errors.
// - High status bit per channel; read clears once condition ended.
// - Main status high summary bit set when any high bit set.
// - Low status bit per channel; read clears once condition ended.
// - Main status low summary bit set when any low bit set.
// - Overtemp status bit per channel set when limit exceeded.
// - Main status overtemp summary bit set when any overtemp bit set.
// - Count fields 000,001,011,111 need one to four conversions; default four overtemp, one alert.
// - Count filters only the outputs; status bits update every conversion.
`timescale 1ns/100ps
`default_nettype none
`include "tmon_regs.svh"
module temp_monitor_status_id_regs #(
  parameter bit         TWO_REMOTE  = 1'b1,           // Two-remote variant when set
  parameter logic [6:0] SLAVE_ADDR  = `TM_SLAVE_ADDR, // Serial slave address
  parameter logic [7:0] MAKER_ID    = 8'h6d,          // Arbitrary value
  parameter logic [7:0] PART_ID_ONE = 8'h81,          // Arbitrary value
  parameter logic [7:0] PART_ID_TWO = 8'h82           // Arbitrary value
) (
  input  wire logic       clk,                // System clock, 125 MHz
  input  wire logic       rst,                // Async reset, active high
  input  wire logic       scl_clk,            // Serial clock pin
  input  wire logic       sda_in,             // Serial data pin level
  output logic            sda_out,            // Serial data drive value, always low
  output logic            sda_oe,             // Pull serial data low
  input  wire logic       conv_done,          // One-cycle pulse per finished conversion
  input  wire logic [1:0] open_cond,          // Remote diode fault, [1]=remote 2
  input  wire logic [2:0] high_cond,          // Above high limit, [0]=local
  input  wire logic [2:0] low_cond,           // Below low limit
  input  wire logic [2:0] ot_cond,            // Above overtemp limit, hysteresis applied
  output logic            alert_out,          // Alert drive value, always low
  output logic            alert_oe,           // Pull alert low
  output logic            overtemp_out,       // Overtemp drive value, always low
  output logic            overtemp_oe,        // Pull overtemp low
  output logic [7:0]      hysteresis_degrees  // Hysteresis for the comparators
);
  localparam logic [7:0] PART_ID = TWO_REMOTE ? PART_ID_TWO : PART_ID_ONE;

  function automatic logic [2:0] need_count(input logic [2:0] f);
    need_count = 3'(f[0]) + 3'(f[1]) + 3'(f[2]) + 3'h1;
  endfunction : need_count

  function automatic logic [2:0] sat_inc(input logic [2:0] c);
    sat_inc = (c == `TM_MAX_CONSEC) ? c : c + 3'h1;
  endfunction : sat_inc

  // Set wins over a read that would clear in the same cycle
  function automatic logic [2:0] flag_next(input logic [2:0] flag, input logic [2:0] cond,
                                           input logic set, input logic rd);
    flag_next = (cond & {3{set}}) | (flag & ~({3{rd}} & ~cond));
  endfunction : flag_next

  logic [2:0] syn;
  logic       bit_raw;
  logic       tgl_raw;
  logic       scl_s;
  logic       sda_s;
  logic       tgl_s;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       tgl_d_r;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;

  tmon_link_sampler u_sampler (
    .scl_clk (scl_clk),
    .rst     (rst),
    .sda_in  (sda_in),
    .bit_r   (bit_raw),
    .tgl_r   (tgl_raw)
  );

  tmon_sync2 #(.WIDTH(3)) u_sync (
    .clk   (clk),
    .rst   (rst),
    .d_in  ({scl_clk, sda_in, tgl_raw}),
    .q_out (syn)
  );

  assign scl_s = syn[2];
  assign sda_s = syn[1];
  assign tgl_s = syn[0];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // Same level as the synchroniser's reset, so release shows no false edge
      scl_d_r <= 1'b0;
      sda_d_r <= 1'b0;
      tgl_d_r <= 1'b0;
    end
    else
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      tgl_d_r <= tgl_s;
    end
  end

  // The bit is read only once its toggle has crossed, so it is long stable by then
  assign rise  = tgl_s ^ tgl_d_r;
  assign fall  = scl_d_r & ~scl_s;
  assign start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  tmon_pkg::bus_state_t st_r;
  tmon_pkg::bus_state_t st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic       rw_r;
  logic       rw_nxt;
  logic       oe_r;
  logic       oe_nxt;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] wbyte;
  logic [7:0] rd_data;
  logic [7:0] status_v;

  logic [7:0] hyst_r;
  logic [7:0] hyst_nxt;
  logic [7:0] ccfg_r;
  logic [7:0] ccfg_nxt;
  logic [2:0] mask_r;
  logic [2:0] mask_nxt;
  logic [1:0] open_r;
  logic [1:0] open_nxt;
  logic [2:0] high_r;
  logic [2:0] high_nxt;
  logic [2:0] low_r;
  logic [2:0] low_nxt;
  logic [2:0] ot_r;
  logic [2:0] ot_nxt;
  logic [2:0][2:0] acnt_r;
  logic [2:0][2:0] acnt_nxt;
  logic [2:0][2:0] ocnt_r;
  logic [2:0][2:0] ocnt_nxt;
  logic [2:0] alert_hit;
  logic [2:0] ot_hit;
  logic [2:0] a_cond;
  logic [2:0] open_tmp;
  logic       alert_nxt;
  logic       overtemp_nxt;

  assign wbyte = {sh_r[6:0], bit_raw};

  always_comb
  begin
    status_v = 8'h00;
    status_v[`TM_ST_HIGH] = |high_r;
    status_v[`TM_ST_LOW]  = |low_r;
    status_v[`TM_ST_OPEN] = |open_r;
    status_v[`TM_ST_OT]   = |ot_r;
    case (ptr_r)
      `TM_OFS_MAKER:  rd_data = MAKER_ID;
      `TM_OFS_PART:   rd_data = PART_ID;
      `TM_OFS_HYST:   rd_data = hyst_r;
      `TM_OFS_CCNT:   rd_data = ccfg_r;
      `TM_OFS_STATUS: rd_data = status_v;
      `TM_OFS_OPEN:   rd_data = {5'h00, open_r, 1'b0};
      `TM_OFS_HIGH:   rd_data = {5'h00, high_r};
      `TM_OFS_LOW:    rd_data = {5'h00, low_r};
      `TM_OFS_OT:     rd_data = {5'h00, ot_r};
      `TM_OFS_MASK:   rd_data = {5'h00, mask_r};
      default:        rd_data = 8'h00;
    endcase
  end

  // Serial slave: address, pointer, write bytes, or repeated reads of the pointed register
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    sh_nxt  = sh_r;
    ptr_nxt = ptr_r;
    tx_nxt  = tx_r;
    rw_nxt  = rw_r;
    oe_nxt  = oe_r;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    if (stop)
    begin
      st_nxt = tmon_pkg::st_idle;
      oe_nxt = 1'b0;
    end
    else if (start)
    begin
      st_nxt  = tmon_pkg::st_addr;
      cnt_nxt = 4'h0;
      oe_nxt  = 1'b0;
    end
    else if (rise)
    begin
      if (cnt_r == `TM_ACK_BIT)
      begin
        cnt_nxt = 4'h0;
        case (st_r)
          tmon_pkg::st_addr:
            if (rw_r)
            begin
              st_nxt = tmon_pkg::st_rdata;
              tx_nxt = rd_data;
              rd_en  = 1'b1;
            end
            else
            begin
              st_nxt = tmon_pkg::st_ptr;
            end
          tmon_pkg::st_ptr:
            st_nxt = tmon_pkg::st_wdata;
          tmon_pkg::st_rdata:
            if (!bit_raw)
            begin
              tx_nxt = rd_data;
              rd_en  = 1'b1;
            end
            else
            begin
              st_nxt = tmon_pkg::st_ignore;
            end
          default:
            st_nxt = st_r;
        endcase
      end
      else
      begin
        sh_nxt  = wbyte;
        cnt_nxt = cnt_r + 4'h1;
        if (cnt_r == `TM_LAST_BIT)
        begin
          case (st_r)
            tmon_pkg::st_addr:
              if (sh_r[6:0] == SLAVE_ADDR)
                rw_nxt = bit_raw;
              else
                st_nxt = tmon_pkg::st_ignore;
            tmon_pkg::st_ptr:
              ptr_nxt = wbyte;
            tmon_pkg::st_wdata:
              wr_en = 1'b1;
            default:
              st_nxt = st_r;
          endcase
        end
      end
    end
    else if (fall)
    begin
      case (st_r)
        tmon_pkg::st_addr,
        tmon_pkg::st_ptr,
        tmon_pkg::st_wdata:
          oe_nxt = (cnt_r == `TM_ACK_BIT);
        tmon_pkg::st_rdata:
          oe_nxt = (cnt_r != `TM_ACK_BIT) && !tx_r[3'h7 - cnt_r[2:0]];
        default:
          oe_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r  <= tmon_pkg::st_idle;
      cnt_r <= 4'h0;
      sh_r  <= 8'h00;
      ptr_r <= 8'h00;
      tx_r  <= 8'h00;
      rw_r  <= 1'b0;
      oe_r  <= 1'b0;
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r  <= sh_nxt;
      ptr_r <= ptr_nxt;
      tx_r  <= tx_nxt;
      rw_r  <= rw_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // Registers, sticky status and the consecutive-conversion filters
  always_comb
  begin
    hyst_nxt = hyst_r;
    ccfg_nxt = ccfg_r;
    mask_nxt = mask_r;
    if (wr_en)
    begin
      case (ptr_r)
        `TM_OFS_HYST: hyst_nxt = wbyte;
        `TM_OFS_CCNT: ccfg_nxt = wbyte & `TM_CCNT_WMASK;
        `TM_OFS_MASK: mask_nxt = wbyte[2:0];
        default:      hyst_nxt = hyst_r;
      endcase
    end
    open_tmp = flag_next({open_r, 1'b0}, {open_cond, 1'b0}, conv_done,
                         rd_en && (ptr_r == `TM_OFS_OPEN));
    open_nxt = open_tmp[2:1];
    high_nxt = flag_next(high_r, high_cond, conv_done,
                         rd_en && (ptr_r == `TM_OFS_HIGH));
    low_nxt  = flag_next(low_r, low_cond, conv_done,
                         rd_en && (ptr_r == `TM_OFS_LOW));
    // Overtemp flags carry no read clear; they follow the comparator each conversion
    ot_nxt   = conv_done ? (ot_r | ot_cond) & ot_cond : ot_r;
    a_cond   = high_cond | low_cond | {open_cond, 1'b0};
    acnt_nxt = acnt_r;
    ocnt_nxt = ocnt_r;
    for (int i = 0; i < `TM_NCH; i++)
    begin
      if (conv_done)
      begin
        acnt_nxt[i] = a_cond[i] ? sat_inc(acnt_r[i]) : 3'h0;
        ocnt_nxt[i] = ot_cond[i] ? sat_inc(ocnt_r[i]) : 3'h0;
      end
      alert_hit[i] = acnt_r[i] >= need_count(ccfg_r[`TM_CCNT_AL_HI:`TM_CCNT_AL_LO]);
      ot_hit[i]    = ocnt_r[i] >= need_count(ccfg_r[`TM_CCNT_OT_HI:`TM_CCNT_OT_LO]);
    end
    alert_nxt    = |(mask_r & alert_hit);
    overtemp_nxt = |ot_hit;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hyst_r       <= `TM_RST_HYST;
      ccfg_r       <= `TM_RST_CCNT;
      mask_r       <= `TM_RST_MASK;
      open_r       <= 2'h0;
      high_r       <= 3'h0;
      low_r        <= 3'h0;
      ot_r         <= 3'h0;
      acnt_r       <= '0;
      ocnt_r       <= '0;
      alert_oe     <= 1'b0;
      overtemp_oe  <= 1'b0;
      sda_oe       <= 1'b0;
      sda_out      <= 1'b0;
      alert_out    <= 1'b0;
      overtemp_out <= 1'b0;
    end
    else
    begin
      hyst_r       <= hyst_nxt;
      ccfg_r       <= ccfg_nxt;
      mask_r       <= mask_nxt;
      open_r       <= open_nxt;
      high_r       <= high_nxt;
      low_r        <= low_nxt;
      ot_r         <= ot_nxt;
      acnt_r       <= acnt_nxt;
      ocnt_r       <= ocnt_nxt;
      alert_oe     <= alert_nxt;
      overtemp_oe  <= overtemp_nxt;
      sda_oe       <= oe_nxt;
      sda_out      <= 1'b0;
      alert_out    <= 1'b0;
      overtemp_out <= 1'b0;
    end
  end

  // Comparators read this live; keeping it below the limits is the host's job
  assign hysteresis_degrees = hyst_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_maker_id;
    rd_en && (ptr_r == `TM_OFS_MAKER) |=> tx_r == MAKER_ID;
  endproperty
  a_maker_id: assert property (p_maker_id) else $error("maker id wrong");

  property p_part_id;
    rd_en && (ptr_r == `TM_OFS_PART) |=> tx_r == (TWO_REMOTE ? PART_ID_TWO : PART_ID_ONE);
  endproperty
  a_part_id: assert property (p_part_id) else $error("part id wrong");

  property p_id_ro;
    wr_en && (ptr_r >= `TM_OFS_PART) |=> $stable(hyst_r) && $stable(ccfg_r) && $stable(mask_r);
  endproperty
  a_id_ro: assert property (p_id_ro) else $error("id write altered a register");

  property p_ccnt_write;
    wr_en && (ptr_r == `TM_OFS_CCNT) |=> ccfg_r == ($past(wbyte) & `TM_CCNT_WMASK);
  endproperty
  a_ccnt_write: assert property (p_ccnt_write) else $error("count register write lost");

  property p_ccnt_zero;
    ccfg_r[7] == 1'b0 && ccfg_r[0] == 1'b0;
  endproperty
  a_ccnt_zero: assert property (p_ccnt_zero) else $error("count register zero bits set");

  property p_hyst_write;
    wr_en && (ptr_r == `TM_OFS_HYST) |=> hyst_r == $past(wbyte) ##1 hysteresis_degrees == hyst_r;
  endproperty
  a_hyst_write: assert property (p_hyst_write) else $error("hysteresis write lost");

  property p_open_hold;
    open_r[1] && !(rd_en && (ptr_r == `TM_OFS_OPEN)) |=> open_r[1];
  endproperty
  a_open_hold: assert property (p_open_hold) else $error("open flag lost without read");

  property p_alert_mask;
    alert_oe |-> $past(mask_r) != 3'h0;
  endproperty
  a_alert_mask: assert property (p_alert_mask) else $error("alert from unmasked channel");

  property p_high_clear;
    rd_en && (ptr_r == `TM_OFS_HIGH) && !conv_done && (high_cond == 3'h0) |=> high_r == 3'h0;
  endproperty
  a_high_clear: assert property (p_high_clear) else $error("high flags not cleared");

  property p_high_sum;
    (high_r != 3'h0) && rd_en && (ptr_r == `TM_OFS_STATUS) |=> tx_r[`TM_ST_HIGH];
  endproperty
  a_high_sum: assert property (p_high_sum) else $error("high summary missing");

  property p_low_set;
    conv_done && low_cond[0] |=> low_r[0];
  endproperty
  a_low_set: assert property (p_low_set) else $error("low flag not set");

  property p_ot_sum;
    conv_done && ot_cond[2] |=> ot_r[2] && status_v[`TM_ST_OT];
  endproperty
  a_ot_sum: assert property (p_ot_sum) else $error("overtemp flag or summary missing");

  property p_ot_filter;
    conv_done && (ot_cond == 3'h0) |=> ##1 !overtemp_oe;
  endproperty
  a_ot_filter: assert property (p_ot_filter) else $error("overtemp held after clear conversion");

  c_write: cover property (wr_en && (ptr_r == `TM_OFS_HYST));
  c_read_id: cover property (rd_en && (ptr_r == `TM_OFS_MAKER));
  c_alert: cover property ($rose(alert_oe));
  c_overtemp: cover property ($rose(overtemp_oe));
endmodule : temp_monitor_status_id_regs
`default_nettype wire

// ==== rtl/tmon_regs.svh ====
// Register offsets, reset values, field positions and link constants of the monitor register bank
`ifndef TMON_REGS_SVH
`define TMON_REGS_SVH

`define TM_SLAVE_ADDR   7'h4c
`define TM_NCH          3

`define TM_OFS_STATUS   8'h02
`define TM_OFS_HYST     8'h21
`define TM_OFS_CCNT     8'h22
`define TM_OFS_OPEN     8'h35
`define TM_OFS_HIGH     8'h36
`define TM_OFS_LOW      8'h37
`define TM_OFS_OT       8'h39
`define TM_OFS_MASK     8'h3a
`define TM_OFS_PART     8'hfd
`define TM_OFS_MAKER    8'hfe

`define TM_RST_HYST     8'h0a
`define TM_RST_CCNT     8'h70
`define TM_RST_MASK     3'h7
`define TM_CCNT_WMASK   8'h7e

`define TM_CCNT_OT_HI   6
`define TM_CCNT_OT_LO   4
`define TM_CCNT_AL_HI   3
`define TM_CCNT_AL_LO   1

`define TM_ST_HIGH      4
`define TM_ST_LOW       3
`define TM_ST_OPEN      2
`define TM_ST_OT        1

`define TM_MAX_CONSEC   3'h4
`define TM_ACK_BIT      4'h8
`define TM_LAST_BIT     4'h7

`endif

// ==== rtl/tmon_pkg.sv ====
// Types shared by the monitor register bank
package tmon_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_ptr,
    st_wdata,
    st_rdata,
    st_ignore
  } bus_state_t;
endpackage : tmon_pkg

// ==== rtl/tmon_sync2.sv ====
// Two-flop level synchroniser into the system clock domain
`timescale 1ns/100ps
`default_nettype none
module tmon_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,    // Destination clock
  input  wire logic             rst,    // Async reset, active high
  input  wire logic [WIDTH-1:0] d_in,   // Asynchronous levels
  output logic      [WIDTH-1:0] q_out   // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] q_nxt;

  always_comb
  begin
    meta_nxt = d_in;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      q_out  <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_out  <= q_nxt;
    end
  end
endmodule : tmon_sync2
`default_nettype wire

// ==== rtl/tmon_link_sampler.sv ====
// Link-clock domain: samples the data line on each rising serial clock edge
`timescale 1ns/100ps
`default_nettype none
module tmon_link_sampler (
  input  wire logic scl_clk,   // Serial clock from the host
  input  wire logic rst,       // Async reset, active high
  input  wire logic sda_in,    // Serial data line level
  output logic      bit_r,     // Data bit taken at the last rising edge
  output logic      tgl_r      // Toggles once per rising edge
);
  logic bit_nxt;
  logic tgl_nxt;

  // The bit stays put until the next edge, far longer than the toggle takes to cross
  always_comb
  begin
    bit_nxt = sda_in;
    tgl_nxt = ~tgl_r;
  end

  always_ff @(posedge scl_clk or posedge rst)
  begin
    if (rst)
    begin
      bit_r <= 1'b0;
      tgl_r <= 1'b0;
    end
    else
    begin
      bit_r <= bit_nxt;
      tgl_r <= tgl_nxt;
    end
  end
endmodule : tmon_link_sampler
`default_nettype wire

// ==== bench/smbus_host_model.sv ====
// Two-wire bus host model: drives the serial clock and pulls the data line low
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model #(
  parameter int HALF = 96  // Clock phase: twelve 8 ns system clock periods, above the six-cycle minimum
) (
  output logic      scl_clk,   // Serial clock, stands high between frames
  output logic      pull_low,  // High while the host pulls data low
  input  wire logic sda_in     // Resolved data line
);
  initial
  begin
    scl_clk  = 1'b1;
    pull_low = 1'b0;
  end
  task automatic bit_out(input logic b);
    pull_low = ~b;
    #(HALF / 2);
    scl_clk = 1'b1;
    #(HALF);
    scl_clk = 1'b0;
    #(HALF / 2);
  endtask : bit_out
  task automatic bit_in(output logic b);
    pull_low = 1'b0;
    #(HALF / 2);
    scl_clk = 1'b1;
    #(HALF / 2);
    b = sda_in;
    #(HALF / 2);
    scl_clk = 1'b0;
    #(HALF / 2);
  endtask : bit_in
  task automatic byte_out(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      bit_out(v[i]);
    bit_in(b);
    ack = ~b;
  endtask : byte_out
  task automatic frame_start();
    #5;  // Keeps link edges off the system clock grid
    pull_low = 1'b0;
    scl_clk  = 1'b1;
    #(HALF);
    pull_low = 1'b1;
    #(HALF);
    scl_clk = 1'b0;
    #(HALF / 2);
  endtask : frame_start
  task automatic frame_stop();
    pull_low = 1'b1;
    #(HALF / 2);
    scl_clk = 1'b1;
    #(HALF);
    pull_low = 1'b0;
    #(HALF);
  endtask : frame_stop
  task automatic xfer_write(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                            input logic with_d, output logic ack);
    logic k1;
    logic k2;
    logic k3;
    frame_start();
    byte_out({a, 1'b0}, k1);
    byte_out(p, k2);
    k3 = 1'b1;
    if (with_d)
      byte_out(d, k3);
    frame_stop();
    ack = k1 & k2 & k3;
  endtask : xfer_write
  task automatic xfer_read(input logic [6:0] a, output logic [7:0] d, output logic ack);
    frame_start();
    byte_out({a, 1'b1}, ack);
    for (int i = 7; i >= 0; i--)
      bit_in(d[i]);
    bit_out(1'b1);  // Not-acknowledge ends the read
    frame_stop();
  endtask : xfer_read
endmodule : smbus_host_model
`default_nettype wire

// ==== bench/test_temp_monitor_status_id_regs.sv ====
// Self-checking bench for the monitor register bank over its two-wire link
`timescale 1ns/100ps
`default_nettype none
`include "tmon_regs.svh"
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      fails++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, got); \
    end \
  end
module test_temp_monitor_status_id_regs;
  localparam logic [6:0] A0    = `TM_SLAVE_ADDR;
  localparam logic [6:0] A1    = 7'h4d;
  localparam logic [7:0] MAKER = 8'h4e;  // Arbitrary value
  localparam logic [7:0] P_ONE = 8'h91;  // Arbitrary value
  localparam logic [7:0] P_TWO = 8'h92;  // Arbitrary value
  logic       clk;
  logic       rst;
  logic       conv_done;
  logic [1:0] open_cond;
  logic [2:0] high_cond;
  logic [2:0] low_cond;
  logic [2:0] ot_cond;
  logic       scl_clk;
  logic       host_pull;
  logic       oe0;
  logic       oe1;
  logic       alert_oe;
  logic       overtemp_oe;
  logic [7:0] hyst;
  logic       drv_sda;
  logic       drv_alert;
  logic       drv_ot;
  wire        sda;
  int         fails;
  int         samples_checked;
  logic [7:0] ofs   [3] = '{`TM_OFS_OPEN, `TM_OFS_HIGH, `TM_OFS_LOW};
  logic [7:0] flg   [3] = '{8'h06, 8'h05, 8'h03};
  logic [7:0] summ  [3] = '{8'h04, 8'h10, 8'h08};
  logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  // Pull-up wins unless some party pulls low
  assign sda = (host_pull | oe0 | oe1) ? 1'b0 : 1'b1;
  temp_monitor_status_id_regs #(.TWO_REMOTE(1'b1), .SLAVE_ADDR(A0), .MAKER_ID(MAKER),
    .PART_ID_ONE(P_ONE), .PART_ID_TWO(P_TWO)) DUT (
    .clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda), .sda_out(drv_sda), .sda_oe(oe0),
    .conv_done(conv_done), .open_cond(open_cond), .high_cond(high_cond), .low_cond(low_cond),
    .ot_cond(ot_cond), .alert_out(drv_alert), .alert_oe(alert_oe), .overtemp_out(drv_ot),
    .overtemp_oe(overtemp_oe),
    .hysteresis_degrees(hyst));
  // Single-remote variant shares the bus at its own address
  temp_monitor_status_id_regs #(.TWO_REMOTE(1'b0), .SLAVE_ADDR(A1), .MAKER_ID(MAKER),
    .PART_ID_ONE(P_ONE), .PART_ID_TWO(P_TWO)) DUT1 (
    .clk(clk), .rst(rst), .scl_clk(scl_clk), .sda_in(sda), .sda_out(), .sda_oe(oe1),
    .conv_done(conv_done), .open_cond(open_cond), .high_cond(high_cond), .low_cond(low_cond),
    .ot_cond(ot_cond), .alert_out(), .alert_oe(), .overtemp_out(), .overtemp_oe(),
    .hysteresis_degrees());
  smbus_host_model #(.HALF(96)) host (.scl_clk(scl_clk), .pull_low(host_pull), .sda_in(sda));
  initial
    clk = 1'b0;
  always #4 clk = ~clk;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic k;
    host.xfer_write(A0, p, d, 1'b1, k);
    `CHK("write ack", 1'b1, k)
  endtask : wr
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] p, input logic [7:0] ex);
    logic       k1;
    logic       k2;
    logic [7:0] v;
    host.xfer_write(a, p, 8'h00, 1'b0, k1);
    host.xfer_read(a, v, k2);
    `CHK("read ack", 2'b11, {k1, k2})
    `CHK($sformatf("reg %h", p), ex, v)
  endtask : rd_chk
  task automatic pulse_conv();
    @(negedge clk);
    conv_done = 1'b1;
    @(negedge clk);
    conv_done = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse_conv
  initial
  begin
    logic k;
    rst       = 1'b1;
    conv_done = 1'b0;
    open_cond = 2'b00;
    high_cond = 3'b000;
    low_cond  = 3'b000;
    ot_cond   = 3'b000;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("hyst port", 8'h0a, hyst)
    rd_chk(A0, `TM_OFS_HYST, 8'h0a);
    rd_chk(A0, `TM_OFS_CCNT, 8'h70);
    rd_chk(A0, `TM_OFS_MASK, 8'h07);
    rd_chk(A0, `TM_OFS_MAKER, MAKER);
    rd_chk(A0, `TM_OFS_PART, P_TWO);
    rd_chk(A1, `TM_OFS_PART, P_ONE);
    rd_chk(A1, `TM_OFS_MAKER, MAKER);
    wr(`TM_OFS_MAKER, 8'h00);
    wr(`TM_OFS_PART, 8'hff);
    rd_chk(A0, `TM_OFS_MAKER, MAKER);
    rd_chk(A0, `TM_OFS_PART, P_TWO);
    wr(`TM_OFS_CCNT, 8'hff);
    rd_chk(A0, `TM_OFS_CCNT, 8'h7e);
    wr(`TM_OFS_HYST, 8'h05);
    rd_chk(A0, `TM_OFS_HYST, 8'h05);
    `CHK("hyst port", 8'h05, hyst)
    host.xfer_write(7'h33, `TM_OFS_HYST, 8'h00, 1'b1, k);
    `CHK("foreign ack", 1'b0, k)
    wr(8'h50, 8'h12);
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk);
      open_cond = (i == 0) ? 2'b11 : 2'b00;
      high_cond = (i == 1) ? 3'b101 : 3'b000;
      low_cond  = (i == 2) ? 3'b011 : 3'b000;
      pulse_conv();
      rd_chk(A0, ofs[i], flg[i]);
      rd_chk(A0, `TM_OFS_STATUS, summ[i]);
      rd_chk(A0, ofs[i], flg[i]);
      @(negedge clk);
      open_cond = 2'b00;
      high_cond = 3'b000;
      low_cond  = 3'b000;
      rd_chk(A0, ofs[i], flg[i]);
      rd_chk(A0, ofs[i], 8'h00);
    end
    for (int n = 0; n < 4; n++)
    begin
      wr(`TM_OFS_CCNT, {1'b0, codes[n], 4'h0});
      @(negedge clk);
      ot_cond = 3'b000;
      pulse_conv();
      @(negedge clk);
      ot_cond = 3'b100;
      repeat (n) pulse_conv();
      if (n == 3)
      begin
        rd_chk(A0, `TM_OFS_OT, 8'h04);
        rd_chk(A0, `TM_OFS_STATUS, 8'h02);
      end
      `CHK("overtemp early", 1'b0, overtemp_oe)
      pulse_conv();
      `CHK("overtemp due", 1'b1, overtemp_oe)
    end
    @(negedge clk);
    ot_cond = 3'b000;
    pulse_conv();
    rd_chk(A0, `TM_OFS_OT, 8'h00);
    `CHK("overtemp off", 1'b0, overtemp_oe)
    wr(`TM_OFS_CCNT, 8'h02);
    @(negedge clk);
    high_cond = 3'b001;
    pulse_conv();
    `CHK("alert early", 1'b0, alert_oe)
    pulse_conv();
    `CHK("alert due", 1'b1, alert_oe)
    `CHK("drive levels", 3'h0, {drv_sda, drv_alert, drv_ot})
    wr(`TM_OFS_MASK, 8'h06);
    pulse_conv();
    `CHK("alert unmasked", 1'b0, alert_oe)
    end_of_test();
  end
  initial
  begin
    #600000;
    fails++;
    end_of_test();
  end
endmodule : test_temp_monitor_status_id_regs
`default_nettype wire
